// ==== peripheral_model.sv ====
// Peripheral device on the adapter's first control lines.
// Assumes the bench raises send for one cycle per new port A word.
`timescale 1ns/1ps
module peripheral_model (
	// Clock
	input wire logic ref_clk,
	// Requests from the bench
	input wire logic send,
	input wire logic hold,
	input wire logic [3:0] lag,
	// Port B second line from the adapter
	input wire logic b_line,
	input wire logic b_oe_n,
	// First control lines
	output logic a_first,
	output logic b_first
);
	logic [4:0] n = 5'h00;
	initial a_first = 1'b1;
	initial b_first = 1'b1;
	// A new word is flagged by one edge, alternating in direction.
	always @(posedge ref_clk)
		if (send)
			a_first <= !a_first;
	// Data available on port B is taken after lag+2 cycles, then acknowledged by a two-cycle low pulse.
	always @(posedge ref_clk)
	begin
		n <= (hold || b_oe_n || b_line) ? 5'h00 : n + 5'h01;
		if (n == 5'(lag) + 5'h01)
			b_first <= 1'b0;
		if (n == 5'(lag) + 5'h03)
			b_first <= 1'b1;
	end
endmodule : peripheral_model

// ==== peripheral_port_handshake_ctrl_bench.sv ====
// Self-checking bench for the adapter through its register port.
// Assumes the adapter, its FIFO and the peripheral model are compiled first.
`timescale 1ns/1ps
module peripheral_port_handshake_ctrl_bench;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] pa_in = 8'h5A;
	logic [7:0] pb_in = 8'hC3;
	logic a_lvl = 1'b1;
	logic send = 1'b0;
	logic hold = 1'b1;
	logic [3:0] lag = 4'h2;
	wire logic [7:0] rdata, pa_out, pa_oe_n, pb_out, pb_oe_n;
	wire logic a1, a2o, a2e, b1, b2o, b2e, ia, ib, fr;
	logic [7:0] got;
	logic al;
	int fails = 0;
	int check_count = 0;
	always #20 ref_clk = !ref_clk;
	port_adapter #(.FIFO_DEPTH(8)) port_adapter_inst (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .port_a_first_control_in(a1),
		.port_a_second_control_line_in(a2e ? a_lvl : a2o), .port_a_second_control_line_out(a2o),
		.port_a_second_control_line_oe_n(a2e), .port_b_first_control_in(b1),
		.port_b_second_control_line_in(b2e ? 1'b1 : b2o), .port_b_second_control_line_out(b2o),
		.port_b_second_control_line_oe_n(b2e), .port_a_interrupt_out_n(ia), .port_b_interrupt_out_n(ib),
		.port_b_fifo_ready(fr));
	peripheral_model peripheral_model_inst (.ref_clk(ref_clk), .send(send), .hold(hold), .lag(lag),
		.b_line(b2o), .b_oe_n(b2e), .a_first(a1), .b_first(b1));
	task test_done;
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wt
	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	task rreg(input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		got = rdata;
		al = a2o;
		chk(got, e);
	endtask : rreg
	task pulse;
		@(posedge ref_clk);
		send <= 1'b1;
		@(posedge ref_clk);
		send <= 1'b0;
		wt(5);
	endtask : pulse
	initial
	begin
		wt(16);
		rst_b <= 1'b1;
		wreg(3'h7, 8'hFF);
		for (int i = 0; i < 8; i++)
			rreg(i[2:0], i == 0 ? 8'h5A : i == 3 ? 8'hC3 : 8'h00);
		wreg(3'h1, 8'hF0);
		wreg(3'h0, 8'h3C);
		rreg(3'h0, 8'h3A);
		chk(pa_oe_n, 8'h0F);
		chk(pa_out, 8'h3C);
		chk(pb_oe_n, 8'hFF);
		wreg(3'h2, 8'h02);
		pulse();
		rreg(3'h2, 8'h02);
		pulse();
		rreg(3'h2, 8'h82);
		chk({7'h00, ia}, 8'h01);
		wreg(3'h2, 8'h03);
		chk({7'h00, ia}, 8'h00);
		rreg(3'h2, 8'h83);
		rreg(3'h0, 8'h3A);
		chk({7'h00, ia}, 8'h01);
		wreg(3'h2, 8'h08);
		a_lvl <= 1'b0;
		wt(5);
		rreg(3'h2, 8'h48);
		chk({6'h00, ia, a2e}, 8'h01);
		wreg(3'h2, 8'h00);
		chk({7'h00, ia}, 8'h01);
		wreg(3'h2, 8'h20);
		rreg(3'h0, 8'h3A);
		chk({7'h00, al}, 8'h00);
		pulse();
		chk({7'h00, a2o}, 8'h01);
		wreg(3'h2, 8'h28);
		rreg(3'h0, 8'h3A);
		chk({7'h00, al}, 8'h00);
		wt(1);
		chk({7'h00, a2o}, 8'h01);
		for (int m = 6; m < 8; m++)
		begin
			wreg(3'h2, 8'(m << 3));
			wreg(3'h5, 8'(m << 3));
			wt(2);
			chk({4'h0, a2e, b2e, a2o, b2o}, {6'h00, m[0], m[0]});
		end
		wreg(3'h5, 8'h20);
		for (int i = 0; i < 10; i++)
		begin
			wreg(3'h3, 8'h10 + 8'(i));
			if (i == 0)
			begin
				wt(1);
				chk({pb_out[6:0], b2o}, 8'h20);
			end
		end
		chk({7'h00, fr}, 8'h00);
		rreg(3'h6, 8'h03);
		hold <= 1'b0;
		for (int i = 0; i < 400 && !(pb_out === 8'h18 && b2o === 1'b1); i++)
			wt(1);
		chk({pb_out[6:0], b2o}, 8'h31);
		rreg(3'h6, 8'h00);
		wreg(3'h5, 8'h28);
		wreg(3'h3, 8'h77);
		wt(1);
		chk({pb_out[6:0], b2o}, 8'hEE);
		wt(1);
		chk({7'h00, b2o}, 8'h01);
		wreg(3'h5, 8'h01);
		chk({7'h00, ib}, 8'h00);
		rreg(3'h3, 8'hC3);
		chk({7'h00, ib}, 8'h01);
		test_done();
	end
endmodule : peripheral_port_handshake_ctrl_bench

// ==== port_adapter.sv ====
// Dual-port peripheral adapter: data ports, control lines, flags and interrupts,
// with an output FIFO in front of port B.
// Assumes pins arrive asynchronously and a register master on ref_clk.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps

// Synchronous FIFO with valid and ready on both sides.
module port_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
		begin
			return '0;
		end
		return p + PW'(1);
	endfunction : next_ptr

	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= next_ptr(wr_ptr);
			end
			if (pop)
			begin
				rd_ptr <= next_ptr(rd_ptr);
			end
			if (push && !pop)
			begin
				count <= count + CW'(1);
			end
			else if (pop && !push)
			begin
				count <= count - CW'(1);
			end
		end
	end

endmodule : port_fifo

// Overview of operation
// - Two 8-bit ports; every line separately programmable as input or output.
// - Four control inputs, two per port, for interrupts or data handshakes.
// - Active first-line edge sets control bit 7; bit 1 picks the edge.
// - Interrupt output low while bit 7 set, only when bit 0 is one.
// - Bit 7 sets on an active edge whatever bit 0 holds.
// - Bit 5 zero makes second line an input; its edge sets bit 6, bit 4 picks edge.
// - In that mode bit 3 enables interrupt from bit 6; bit 6 sets regardless.
// - Port A mode 100: line high on first-line edge, low on data read.
// - Port A mode 101: line low for one cycle after each data read.
// - Port B mode 100: line low on data write, high on first-line edge.
// - Port B mode 101: line low for one cycle after each data write.
module port_adapter #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Port A data pins
	input wire logic [7:0] pa_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe_n,
	// Port B data pins
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe_n,
	// Port A control lines
	input wire logic port_a_first_control_in,
	input wire logic port_a_second_control_line_in,
	output logic port_a_second_control_line_out,
	output logic port_a_second_control_line_oe_n,
	// Port B control lines
	input wire logic port_b_first_control_in,
	input wire logic port_b_second_control_line_in,
	output logic port_b_second_control_line_out,
	output logic port_b_second_control_line_oe_n,
	// Interrupts
	output logic port_a_interrupt_out_n,
	output logic port_b_interrupt_out_n,
	// Port B write buffer has room
	output logic port_b_fifo_ready
);

	logic [5:0] ctrl [2];
	logic [1:0] c1_flag;
	logic [1:0] c2_flag;
	logic [1:0] line_out;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] out_a;
	logic [7:0] out_b;
	logic [7:0] pa_s1;
	logic [7:0] pa_s2;
	logic [7:0] pb_s1;
	logic [7:0] pb_s2;
	logic [1:0] c1_s1;
	logic [1:0] c1_s2;
	logic [1:0] c1_prev;
	logic [1:0] c2_s1;
	logic [1:0] c2_s2;
	logic [1:0] c2_prev;
	logic [1:0] c1_edge;
	logic [1:0] c2_edge;
	logic [1:0] data_ev;
	logic [1:0] flag_clr;
	logic [2:0] mode [2];
	logic fifo_valid;
	logic fifo_take;
	logic [7:0] fifo_data;
	logic b_slot_free;
	logic [7:0] next_rdata;

	function automatic logic active_edge(input logic prev, input logic cur, input logic pos);
		return pos ? (~prev & cur) : (prev & ~cur);
	endfunction : active_edge

	function automatic logic [7:0] port_view(input logic [7:0] pins, input logic [7:0] outs,
		input logic [7:0] dir);
		return (pins & ~dir) | (outs & dir);
	endfunction : port_view

	function automatic logic [7:0] ctrl_view(input logic f1, input logic f2, input logic [5:0] c);
		return {f1, f2, c};
	endfunction : ctrl_view

	// Every pin from outside passes two flip-flops before use.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pa_s1 <= 8'h00;
			pa_s2 <= 8'h00;
			pb_s1 <= 8'h00;
			pb_s2 <= 8'h00;
			c1_s1 <= 2'h3;
			c1_s2 <= 2'h3;
			c1_prev <= 2'h3;
			c2_s1 <= 2'h3;
			c2_s2 <= 2'h3;
			c2_prev <= 2'h3;
		end
		else
		begin
			pa_s1 <= pa_in;
			pa_s2 <= pa_s1;
			pb_s1 <= pb_in;
			pb_s2 <= pb_s1;
			c1_s1 <= {port_b_first_control_in, port_a_first_control_in};
			c1_s2 <= c1_s1;
			c1_prev <= c1_s2;
			c2_s1 <= {port_b_second_control_line_in, port_a_second_control_line_in};
			c2_s2 <= c2_s1;
			c2_prev <= c2_s2;
		end
	end

	// Port B writes are buffered; the drain waits on the peripheral in handshake mode.
	port_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) b_fifo (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.in_valid(wr && (addr == port_adapter_pkg::ADDR_B_DATA)),
		.in_ready(port_b_fifo_ready),
		.in_data(wdata),
		.out_valid(fifo_valid),
		.out_ready(b_slot_free),
		.out_data(fifo_data)
	);

	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			mode[i] = ctrl[i][port_adapter_pkg::C2_OUT:port_adapter_pkg::C2_IRQ_EN];
			c1_edge[i] = active_edge(c1_prev[i], c1_s2[i], ctrl[i][port_adapter_pkg::C1_POS]);
			c2_edge[i] = ~ctrl[i][port_adapter_pkg::C2_OUT] &
				active_edge(c2_prev[i], c2_s2[i], ctrl[i][port_adapter_pkg::C2_POS]);
		end
		b_slot_free = (mode[port_adapter_pkg::PORT_B] != port_adapter_pkg::MODE_HANDSHAKE) ||
			line_out[port_adapter_pkg::PORT_B];
		fifo_take = fifo_valid & b_slot_free;
		data_ev[port_adapter_pkg::PORT_A] = rd && (addr == port_adapter_pkg::ADDR_A_DATA);
		data_ev[port_adapter_pkg::PORT_B] = fifo_take;
		flag_clr[port_adapter_pkg::PORT_A] = rd && (addr == port_adapter_pkg::ADDR_A_DATA);
		flag_clr[port_adapter_pkg::PORT_B] = rd && (addr == port_adapter_pkg::ADDR_B_DATA);
	end

	// Control registers: bits 5..0 written by software, flags are read-only.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl[0] <= port_adapter_pkg::CTRL_RESET;
			ctrl[1] <= port_adapter_pkg::CTRL_RESET;
		end
		else if (wr && (addr == port_adapter_pkg::ADDR_A_CTRL))
		begin
			ctrl[0] <= wdata[5:0];
		end
		else if (wr && (addr == port_adapter_pkg::ADDR_B_CTRL))
		begin
			ctrl[1] <= wdata[5:0];
		end
	end

	// Flags set on active edges whatever the enables hold; a set beats a clear.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			c1_flag <= 2'h0;
			c2_flag <= 2'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (c1_edge[i])
				begin
					c1_flag[i] <= 1'b1;
				end
				else if (flag_clr[i])
				begin
					c1_flag[i] <= 1'b0;
				end
				if (c2_edge[i])
				begin
					c2_flag[i] <= 1'b1;
				end
				else if (flag_clr[i])
				begin
					c2_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Direction and output data registers.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dir_a <= port_adapter_pkg::DIR_RESET;
			dir_b <= port_adapter_pkg::DIR_RESET;
			out_a <= port_adapter_pkg::DATA_RESET;
		end
		else if (wr && (addr == port_adapter_pkg::ADDR_A_DIR))
		begin
			dir_a <= wdata;
		end
		else if (wr && (addr == port_adapter_pkg::ADDR_B_DIR))
		begin
			dir_b <= wdata;
		end
		else if (wr && (addr == port_adapter_pkg::ADDR_A_DATA))
		begin
			out_a <= wdata;
		end
	end

	// Port B output latch loads from the FIFO head, which is the write event.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_b <= port_adapter_pkg::DATA_RESET;
		end
		else if (fifo_take)
		begin
			out_b <= fifo_data;
		end
	end

	// Second control line output level per mode.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_out <= {2{port_adapter_pkg::LINE_RESET}};
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				case (mode[i])
					port_adapter_pkg::MODE_HANDSHAKE:
					begin
						// Port A: new data edge wins over a read. Port B: a pending write wins.
						if (i == port_adapter_pkg::PORT_A && c1_edge[i])
						begin
							line_out[i] <= 1'b1;
						end
						else if (data_ev[i])
						begin
							line_out[i] <= 1'b0;
						end
						else if (c1_edge[i])
						begin
							line_out[i] <= 1'b1;
						end
					end
					port_adapter_pkg::MODE_PULSE:
					begin
						line_out[i] <= ~data_ev[i];
					end
					port_adapter_pkg::MODE_LOW:
					begin
						line_out[i] <= 1'b0;
					end
					port_adapter_pkg::MODE_HIGH:
					begin
						line_out[i] <= 1'b1;
					end
					default:
					begin
						line_out[i] <= port_adapter_pkg::LINE_RESET;
					end
				endcase
			end
		end
	end

	// Read mux; data stand in the cycle after the strobe only.
	always_comb
	begin
		next_rdata = port_adapter_pkg::READ_RESET;
		if (!rd)
		begin
			next_rdata = port_adapter_pkg::READ_RESET;
		end
		else if (addr == port_adapter_pkg::ADDR_A_DATA)
		begin
			next_rdata = port_view(pa_s2, out_a, dir_a);
		end
		else if (addr == port_adapter_pkg::ADDR_A_DIR)
		begin
			next_rdata = dir_a;
		end
		else if (addr == port_adapter_pkg::ADDR_A_CTRL)
		begin
			next_rdata = ctrl_view(c1_flag[0], c2_flag[0], ctrl[0]);
		end
		else if (addr == port_adapter_pkg::ADDR_B_DATA)
		begin
			next_rdata = port_view(pb_s2, out_b, dir_b);
		end
		else if (addr == port_adapter_pkg::ADDR_B_DIR)
		begin
			next_rdata = dir_b;
		end
		else if (addr == port_adapter_pkg::ADDR_B_CTRL)
		begin
			next_rdata = ctrl_view(c1_flag[1], c2_flag[1], ctrl[1]);
		end
		else if (addr == port_adapter_pkg::ADDR_STATUS)
		begin
			next_rdata[port_adapter_pkg::ST_PENDING] = fifo_valid;
			next_rdata[port_adapter_pkg::ST_FULL] = ~port_b_fifo_ready;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata <= port_adapter_pkg::READ_RESET;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	// Pin drivers; a set direction bit drives the line.
	assign pa_out = out_a;
	assign pa_oe_n = ~dir_a;
	assign pb_out = out_b;
	assign pb_oe_n = ~dir_b;
	assign port_a_second_control_line_out = line_out[0];
	assign port_a_second_control_line_oe_n = ~ctrl[0][port_adapter_pkg::C2_OUT];
	assign port_b_second_control_line_out = line_out[1];
	assign port_b_second_control_line_oe_n = ~ctrl[1][port_adapter_pkg::C2_OUT];

	// Interrupt outputs from flags and enables.
	assign port_a_interrupt_out_n = ~((c1_flag[0] & ctrl[0][port_adapter_pkg::C1_IRQ_EN]) |
		(c2_flag[0] & ctrl[0][port_adapter_pkg::C2_IRQ_EN] & ~ctrl[0][port_adapter_pkg::C2_OUT]));
	assign port_b_interrupt_out_n = ~((c1_flag[1] & ctrl[1][port_adapter_pkg::C1_IRQ_EN]) |
		(c2_flag[1] & ctrl[1][port_adapter_pkg::C2_IRQ_EN] & ~ctrl[1][port_adapter_pkg::C2_OUT]));

endmodule : port_adapter

// ==== port_adapter_checker.sv ====
// Assertions on the adapter's control lines, port A interrupt and register port.
// Assumes it is bound to port_adapter and sees only its ports.
`timescale 1ns/1ps
module port_adapter_checker #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// Pins
	input wire logic [7:0] pb_out,
	input wire logic port_a_second_control_line_out,
	input wire logic port_a_second_control_line_oe_n,
	input wire logic port_b_second_control_line_out,
	input wire logic port_b_second_control_line_oe_n,
	input wire logic port_a_interrupt_out_n
);
	wire logic al = port_a_second_control_line_out;
	wire logic aoe = port_a_second_control_line_oe_n;
	wire logic bl = port_b_second_control_line_out;
	wire logic boe = port_b_second_control_line_oe_n;
	wire logic irq = port_a_interrupt_out_n;
	// Shadow copies of the writable control bits.
	logic [5:0] sa;
	logic [5:0] sb;
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			sa <= 6'h00;
		else if (wr && addr == 3'h2)
			sa <= wdata[5:0];
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			sb <= 6'h00;
		else if (wr && addr == 3'h5)
			sb <= wdata[5:0];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	property p_irq_off;
		!sa[0] && !(sa[3] && !sa[5]) |-> irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq low while off");
	property p_irq_flag;
		rd && addr == 3'h2 && sa[0] && !(sa[3] && !sa[5]) |=> rdata[7] != $past(irq);
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq and flag differ");
	property p_a_pulse;
		sa[5:3] == 3'h5 && rd && addr == 3'h0 |=> !al;
	endproperty
	a_a_pulse: assert property (p_a_pulse) else $error("no taken pulse");
	property p_a_low;
		sa[5:3] == 3'h6 && $past(sa[5:3]) == 3'h6 |-> !al && !aoe;
	endproperty
	a_a_low: assert property (p_a_low) else $error("manual low wrong");
	property p_b_high;
		sb[5:3] == 3'h7 && $past(sb[5:3]) == 3'h7 |-> bl;
	endproperty
	a_b_high: assert property (p_b_high) else $error("manual high wrong");
	property p_a_in;
		!sa[5] && !$past(sa[5]) |-> aoe && al;
	endproperty
	a_a_in: assert property (p_a_in) else $error("input mode drives");
	property p_b_out;
		sb[5] && $past(sb[5]) |-> !boe;
	endproperty
	a_b_out: assert property (p_b_out) else $error("output mode idle");
	property p_b_pulse;
		sb[5:3] == 3'h5 && $past(sb[5:3]) == 3'h5 && $changed(pb_out) |-> !bl;
	endproperty
	a_b_pulse: assert property (p_b_pulse) else $error("no data pulse");
	c_clear: cover property (rd && addr == 3'h0 && !irq);
	c_b_low: cover property ($fell(bl));
	c_a_hs: cover property (sa[5:3] == 3'h4 && al);
endmodule : port_adapter_checker

bind port_adapter port_adapter_checker #(.FIFO_DEPTH(FIFO_DEPTH)) port_adapter_checker_inst (
	.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.pb_out(pb_out), .port_a_second_control_line_out(port_a_second_control_line_out),
	.port_a_second_control_line_oe_n(port_a_second_control_line_oe_n),
	.port_b_second_control_line_out(port_b_second_control_line_out),
	.port_b_second_control_line_oe_n(port_b_second_control_line_oe_n),
	.port_a_interrupt_out_n(port_a_interrupt_out_n));

// ==== port_adapter_pkg.sv ====
// Constants of the dual-port peripheral adapter; its FIFO uses none of them.
// Assumes a single clock domain and the plain strobe register port.
package port_adapter_pkg;

	// Register map, word addresses on the plain register port.
	localparam logic [2:0] ADDR_A_DATA = 3'h0;
	localparam logic [2:0] ADDR_A_DIR = 3'h1;
	localparam logic [2:0] ADDR_A_CTRL = 3'h2;
	localparam logic [2:0] ADDR_B_DATA = 3'h3;
	localparam logic [2:0] ADDR_B_DIR = 3'h4;
	localparam logic [2:0] ADDR_B_CTRL = 3'h5;
	localparam logic [2:0] ADDR_STATUS = 3'h6;

	// Control register field positions.
	localparam int C1_IRQ_EN = 0;
	localparam int C1_POS = 1;
	localparam int C2_IRQ_EN = 3;
	localparam int C2_POS = 4;
	localparam int C2_OUT = 5;
	localparam int C2_FLAG = 6;
	localparam int C1_FLAG = 7;

	// Status register field positions.
	localparam int ST_PENDING = 0;
	localparam int ST_FULL = 1;

	// Second control line output modes, control bits 5..3.
	localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
	localparam logic [2:0] MODE_PULSE = 3'h5;
	localparam logic [2:0] MODE_LOW = 3'h6;
	localparam logic [2:0] MODE_HIGH = 3'h7;

	// Values after reset.
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic LINE_RESET = 1'b1;
	localparam logic [7:0] READ_RESET = 8'h00;

	// Port indices into the per-port arrays.
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;

endpackage : port_adapter_pkg
